// file: include/cnv_pkg.sv
// Constants shared by the converter start and read-port control logic
package cnv_pkg;

  // ==========================================
  // Timing
  localparam int CLK_FREQ_HZ = 250_000_000;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PWRUP_PULSE_NS = 1500;
  localparam int CONV_TIME_NS = 4500;
  // Least times round up to whole cycles
  localparam int PWRUP_PULSE_CYC = (PWRUP_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CONV_TIME_CYC = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  // ==========================================
  // Data
  localparam int DATA_W = 8;
  localparam logic [7:0] RESULT_RST = 8'h00;

  // ==========================================
  // Sequencer states
  typedef enum logic [1:0] {
    ST_TRACK = 2'b00,
    ST_CONV = 2'b01
  } seq_state_t;

endpackage

// file: logic/cnv_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module cnv_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic din, // Asynchronous input
  output logic dout // Filtered level
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic out_r;

  // Shift chain; first stage read only by second
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      out_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        out_r <= s3_r;
      end
    end
  end

  assign dout = out_r;

endmodule

// file: logic/cnv_ctrl.sv
// Convert-start timing, conversion sequencer, result latch and read port
`timescale 1ns/100ps
module cnv_ctrl #(
  parameter int PULSE_CYC = cnv_pkg::PWRUP_PULSE_CYC, // Internal pulse length
  parameter int CONV_CYC = cnv_pkg::CONV_TIME_CYC // Conversion length
) (
  input wire logic CLK, // System clock
  input wire logic RST, // Synchronous reset, high
  input wire logic CONVERT_START_N, // Convert start pin, low active
  input wire logic CS_N, // Chip select, low active
  input wire logic RD_N, // Read strobe, low active
  input wire logic [cnv_pkg::DATA_W-1:0] SAMPLE, // Quantiser code from analog core
  output logic [cnv_pkg::DATA_W-1:0] DATA_O, // Data bus output
  output logic [cnv_pkg::DATA_W-1:0] DATA_OE_N, // Data bus enables, low drives
  output logic BUSY, // Conversion in progress
  output logic HOLD, // Sampler in hold
  output logic POWERED, // Converter powered up
  output logic CONT_MODE // Continuous mode chosen at last end
);
  import cnv_pkg::*;

  // ==========================================
  // Input conditioning
  // The start, chip-select and read pins each cross into the clock domain through their own filter, so a
  // glitch shorter than one clock never reaches the sequencer or the port.
  // The start filter resets low to match the level held at power-on.
  logic start_n_s;
  logic cs_n_s;
  logic rd_n_s;

  cnv_sync #(.RST_VAL(1'b0)) u_sync_start (
    .clk(CLK),
    .rst(RST),
    .din(CONVERT_START_N),
    .dout(start_n_s)
  );
  cnv_sync #(.RST_VAL(1'b1)) u_sync_cs (
    .clk(CLK),
    .rst(RST),
    .din(CS_N),
    .dout(cs_n_s)
  );
  cnv_sync #(.RST_VAL(1'b1)) u_sync_rd (
    .clk(CLK),
    .rst(RST),
    .din(RD_N),
    .dout(rd_n_s)
  );

  // ==========================================
  // Start edges and internal pulse
  logic start_prev_r;
  logic pulse_r;
  logic pulse_nxt;
  logic [CNT_W-1:0] pcnt_r;
  logic [CNT_W-1:0] pcnt_nxt;
  logic gated_prev_r;
  logic start_rise;
  logic gated;
  logic gated_fall;

  assign start_rise = start_n_s & ~start_prev_r;
  // Gated start: high while either source is high
  assign gated = start_n_s | pulse_r;
  // Later of the two falling edges starts the conversion
  assign gated_fall = gated_prev_r & ~gated;

  // Pulse counter restarts on each rising start edge
  // Retriggering keeps the gated start high long enough for power-up even
  // when a short start pulse arrives shortly after the previous one
  always_comb begin
    pulse_nxt = pulse_r;
    pcnt_nxt = pcnt_r;
    if (start_rise) begin
      pulse_nxt = 1'b1;
      pcnt_nxt = CNT_W'(PULSE_CYC - 1);
    end else if (pulse_r) begin
      if (pcnt_r == '0) begin
        pulse_nxt = 1'b0;
      end else begin
        pcnt_nxt = pcnt_r - CNT_W'(1);
      end
    end
  end

  // Edge history and pulse state
  always_ff @(posedge CLK) begin
    if (RST) begin
      start_prev_r <= 1'b0;
      gated_prev_r <= 1'b0;
      pulse_r <= 1'b0;
      pcnt_r <= '0;
    end else begin
      start_prev_r <= start_n_s;
      gated_prev_r <= gated;
      pulse_r <= pulse_nxt;
      pcnt_r <= pcnt_nxt;
    end
  end

  // ==========================================
  // Power state
  logic powered_r;
  logic powered_nxt;
  logic conv_done;
  logic cont_r;
  logic cont_nxt;

  // Rising start powers up; end of conversion in mode 2 powers down
  // A rise in the end-of-conversion cycle wins, so the next start still
  // finds the converter powered
  always_comb begin
    powered_nxt = powered_r;
    cont_nxt = cont_r;
    if (conv_done) begin
      cont_nxt = start_n_s;
      if (!start_n_s) begin
        powered_nxt = 1'b0;
      end else begin
        powered_nxt = 1'b1;
      end
    end
    if (start_rise) begin
      powered_nxt = 1'b1;
    end
  end

  // Comes out of reset powered down
  always_ff @(posedge CLK) begin
    if (RST) begin
      powered_r <= 1'b0;
      cont_r <= 1'b0;
    end else begin
      powered_r <= powered_nxt;
      cont_r <= cont_nxt;
    end
  end

  // ==========================================
  // Conversion sequencer
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [CNT_W-1:0] ccnt_r;
  logic [CNT_W-1:0] ccnt_nxt;
  logic conv_go;

  // A conversion needs the converter powered
  // A gated fall while still powered down is dropped: no result would be valid
  assign conv_go = gated_fall & powered_r;
  assign conv_done = (state_r == ST_CONV) && (ccnt_r == '0);

  // Track until gated start falls, convert for fixed time
  always_comb begin
    state_nxt = state_r;
    ccnt_nxt = ccnt_r;
    case (state_r)
      ST_TRACK: begin
        if (conv_go) begin
          state_nxt = ST_CONV;
          ccnt_nxt = CNT_W'(CONV_CYC - 1);
        end
      end
      ST_CONV: begin
        if (conv_done) begin
          state_nxt = ST_TRACK;
        end else begin
          ccnt_nxt = ccnt_r - CNT_W'(1);
        end
      end
      default: begin
        state_nxt = ST_TRACK;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge CLK) begin
    if (RST) begin
      state_r <= ST_TRACK;
      ccnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      ccnt_r <= ccnt_nxt;
    end
  end

  // ==========================================
  // Result register
  logic [DATA_W-1:0] result_r;
  logic [DATA_W-1:0] result_nxt;

  // Straight-binary code captured as busy falls
  assign result_nxt = conv_done ? SAMPLE : result_r;

  // Result holds between conversions, also while powered down
  always_ff @(posedge CLK) begin
    if (RST) begin
      result_r <= RESULT_RST;
    end else begin
      result_r <= result_nxt;
    end
  end

  // ==========================================
  // Parallel read port
  logic rd_en_nxt;
  logic busy_rise;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] oe_n_r;
  logic [DATA_W-1:0] oe_n_nxt;

  assign busy_rise = conv_go & (state_r == ST_TRACK);
  // Port cleared at conversion start only; a gated fall while powered down leaves it alone
  // A read held across the start is cut for one cycle, then drives again
  assign rd_en_nxt = busy_rise ? 1'b0 : (~cs_n_s & ~rd_n_s);

  // ==========================================
  // Output stage, one flop pair per data bit
  genvar gi;
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_bit
      // Bit lets go of the bus unless the read enable is set
      assign oe_n_nxt[gi] = ~rd_en_nxt;
      // Enable and data flop per bit keep the bus turn-on aligned
      always_ff @(posedge CLK) begin
        if (RST) begin
          oe_n_r[gi] <= 1'b1;
          dout_r[gi] <= RESULT_RST[gi];
        end else begin
          oe_n_r[gi] <= oe_n_nxt[gi];
          dout_r[gi] <= result_r[gi];
        end
      end
    end
  endgenerate

  // ==========================================
  // Outputs
  assign DATA_O = dout_r;
  assign DATA_OE_N = oe_n_r;
  assign BUSY = (state_r == ST_CONV);
  assign HOLD = (state_r == ST_CONV);
  assign POWERED = powered_r;
  assign CONT_MODE = cont_r;

endmodule

// file: tb/cnv_ctrl_checker.sv
// Port assertions for the converter control block
`timescale 1ns/100ps
module cnv_ctrl_checker #(
  parameter int CONV_CYC = 20 // Conversion length
) (
  input wire logic CLK, // Clock
  input wire logic RST, // Reset
  input wire logic CS_N, // Chip select
  input wire logic RD_N, // Read strobe
  input wire logic [7:0] DATA_O, // Data out
  input wire logic [7:0] DATA_OE_N, // Enables
  input wire logic BUSY, // Busy
  input wire logic HOLD, // Hold
  input wire logic POWERED, // Powered
  input wire logic CONT_MODE // Mode
);
  localparam int C1 = CONV_CYC - 1;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================
  // Timing and read port
  a_busy_length: assert property ($rose(BUSY) |-> ##C1 BUSY ##1 !BUSY) else $error("busy length");
  a_hold_busy: assert property (HOLD == BUSY) else $error("hold not busy");
  a_pulse_min: assert property ($rose(POWERED) |-> !BUSY [*8]) else $error("early start");
  a_start_powered: assert property ($rose(BUSY) |-> $past(POWERED)) else $error("unpowered start");
  a_mode_power: assert property ($fell(BUSY) |-> ##1 (CONT_MODE == POWERED)) else $error("mode");
  a_result_latch: assert property ($changed(DATA_O) |-> $past(BUSY, 1) || $past(BUSY, 2)) else $error("data");
  a_bus_idle: assert property ((CS_N || RD_N) [*8] |-> DATA_OE_N == 8'hFF) else $error("bus on");
  a_port_reset: assert property ($rose(BUSY) |-> ##[0:1] DATA_OE_N == 8'hFF) else $error("port");
  c_cont: cover property ($rose(CONT_MODE));
  c_pdown: cover property ($fell(POWERED));
  c_read: cover property ($fell(DATA_OE_N[0]));
endmodule
bind cnv_ctrl cnv_ctrl_checker #(.CONV_CYC(CONV_CYC)) u_chk (.CLK(CLK), .RST(RST), .CS_N(CS_N), .RD_N(RD_N),
  .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .BUSY(BUSY), .HOLD(HOLD), .POWERED(POWERED), .CONT_MODE(CONT_MODE));

// file: tb/cnv_host.sv
// Host model on the parallel read port
`timescale 1ns/100ps
module cnv_host (
  input wire logic CLK, // Clock
  input wire logic [7:0] DATA_O, // Device data
  input wire logic [7:0] DATA_OE_N, // Device enables
  input wire logic BUSY, // Conversion flag
  output logic CS_N, // Chip select
  output logic RD_N // Read strobe
);
  logic [7:0] bus;
  // Undriven bus reads back the inverse
  assign bus = (DATA_OE_N == 8'h00) ? DATA_O : ~DATA_O;
  initial begin
    CS_N = 1'b1;
    RD_N = 1'b1;
  end
  // One read, never during conversion
  task automatic rd(output logic [7:0] d);
    int n;
    while (BUSY !== 1'b0) @(negedge CLK);
    CS_N = 1'b0;
    RD_N = 1'b0;
    for (n = 0; n < 20 && DATA_OE_N !== 8'h00; n++) @(negedge CLK);
    d = bus;
    @(negedge CLK);
    CS_N = 1'b1;
    RD_N = 1'b1;
    repeat (30) @(negedge CLK);
  endtask
endmodule

// file: tb/tb_adc_convert_start_and_parallel_read.sv
// Self-checking bench for converter start and read control
`timescale 1ns/100ps
module tb_adc_convert_start_and_parallel_read;
  import cnv_pkg::*;
  localparam int PC = 8;
  localparam int CC = 20;
  logic CLK, RST, CONVERT_START_N, CS_N, RD_N, BUSY, HOLD, POWERED, CONT_MODE;
  logic [7:0] SAMPLE, DATA_O, DATA_OE_N, rd_d;
  int n_errors, num_checks;
  cnv_ctrl #(.PULSE_CYC(PC), .CONV_CYC(CC)) dut (.CLK(CLK), .RST(RST), .CONVERT_START_N(CONVERT_START_N),
    .CS_N(CS_N), .RD_N(RD_N), .SAMPLE(SAMPLE), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .BUSY(BUSY),
    .HOLD(HOLD), .POWERED(POWERED), .CONT_MODE(CONT_MODE));
  cnv_host host (.CLK(CLK), .DATA_O(DATA_O), .DATA_OE_N(DATA_OE_N), .BUSY(BUSY), .CS_N(CS_N), .RD_N(RD_N));
  // ==========================================
  // Clock and helpers
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Busy must rise inside a cycle window
  task automatic busy_in(input int lo, input int hi);
    int n;
    for (n = 0; n < hi && BUSY !== 1'b1; n++) @(negedge CLK);
    chk(8'(n >= lo && BUSY === 1'b1), 8'h01);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic s_reset;
    chk({4'h0, BUSY, HOLD, POWERED, CONT_MODE}, 8'h00);
    chk(DATA_OE_N, 8'hFF);
    repeat (40) @(negedge CLK);
    chk(8'(BUSY), 8'h00);
  endtask
  task automatic s_pdown;
    SAMPLE = 8'hA5;
    CONVERT_START_N = 1'b1;
    repeat (2) @(negedge CLK);
    CONVERT_START_N = 1'b0;
    busy_in(PC - 2, PC + 8);
    repeat (CC + 4) @(negedge CLK);
    chk({6'h0, POWERED, CONT_MODE}, 8'h00);
    host.rd(rd_d);
    chk(rd_d, 8'hA5);
    chk(DATA_OE_N, 8'hFF);
  endtask
  task automatic s_cont;
    SAMPLE = 8'h3C;
    CONVERT_START_N = 1'b1;
    repeat (PC + 10) @(negedge CLK);
    chk(8'(BUSY), 8'h00);
    CONVERT_START_N = 1'b0;
    busy_in(2, 8);
    repeat (4) @(negedge CLK);
    CONVERT_START_N = 1'b1;
    repeat (CC + 4) @(negedge CLK);
    chk({6'h0, POWERED, CONT_MODE}, 8'h03);
    host.rd(rd_d);
    chk(rd_d, 8'h3C);
    SAMPLE = 8'h5A;
    CONVERT_START_N = 1'b0;
    busy_in(2, 8);
    repeat (CC + 4) @(negedge CLK);
    chk({6'h0, POWERED, CONT_MODE}, 8'h00);
    host.rd(rd_d);
    chk(rd_d, 8'h5A);
  endtask
  initial begin
    RST = 1'b1;
    CONVERT_START_N = 1'b0;
    SAMPLE = 8'h00;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(negedge CLK);
    RST = 1'b0;
    s_reset;
    s_pdown;
    s_cont;
    end_of_test;
  end
  // Watchdog
  initial begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule
